// ==== rtl/id_capture_dma.sv ====
// Self-ID capture DMA: APB registers, capture sequencer, host write port
//
// Summary of operation
// R1 - Base register holds 2K-aligned buffer address; capture writes start there.
// R2 - Base register content is undefined after chip reset.
// R3 - Error flag set on any error in latest capture; buffer then undefined.
// R4 - Error flag cleared when a capture ends without error.
// R5 - Receive hardware errors and failed host writes both count as errors.
// R6 - Generation counter increments per capture start, wraps after 255.
// R7 - Length field counts captured quadlets, cleared when a bus reset begins.
// R8 - Length clear coincides with the bus-reset event.
// R9 - A bus reset during capture restarts it, overwriting the buffer.
// R10 - First stored quadlet carries the generation count.
// R11 - First quadlet also carries 3 seconds bits and 13 tick bits.
// R12 - Following quadlets are all packets from reset end to subaction gap.
// R13 - Data and inverted check quadlets both stored, no check made.
// R14 - After an error, further packets of that sequence are discarded.
// R15 - Reaching 2048 bytes loads length all ones and sets the error flag.
// R16 - Software checks generation in memory against register before trusting.
// R17 - Packets are captured only while the accept bit is set.
// R18 - Software loads the base before setting the accept bit.
// R19 - End of the self-ID phase raises the phase-done event.
// R20 - Packets outside the phase bypass this buffer to the request path.
// R21 - Write pointer restarts at base each capture, one quadlet per word.
`default_nettype none
module id_capture_dma (
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Physical layer receive path
	input  wire logic                     bus_reset,
	input  wire logic                     id_phase,
	input  wire logic                     rx_error,
	input  wire id_capture_pkg::quad_t    id_in,
	input  wire logic [31:0]              bus_cycle_timer,
	// Host memory write port
	output id_capture_pkg::mem_wr_t       mem_wr,
	input  wire logic                     mem_ready,
	input  wire logic                     mem_err,
	// Request-path forward and events
	output id_capture_pkg::quad_t         fwd,
	output logic                          bus_reset_event,
	output logic                          id_phase_done_event
);
	// ==========================================================
	// Registers
	localparam int BASE_OFF = id_capture_pkg::BASE_LSB;
	logic [31:BASE_OFF] id_buffer_base;
	logic                    accept_id_packets;
	logic [7:0]              id_round_counter;
	logic [8:0]              id_quadlet_length;
	logic                    id_capture_error;
	logic                    cap_err_reg;
	logic                    pend_reg;
	logic [8:0]              idx_reg;
	logic                    br_q;
	logic                    ph_q;
	id_capture_pkg::state_t  state_reg;
	id_capture_pkg::quad_t   fwd_reg;
	id_capture_pkg::mem_wr_t mem_reg;
	logic [31:0]             prdata_reg;
	logic                    rst_evt_reg;
	logic                    done_evt_reg;

	// ==========================================================
	// Bus decode
	wire sel_base  = paddr == id_capture_pkg::OFF_BASE;
	wire sel_count = paddr == id_capture_pkg::OFF_COUNT;
	wire sel_ctrl  = paddr == id_capture_pkg::OFF_CTRL;
	wire mapped    = sel_base | sel_count | sel_ctrl;
	wire setup     = psel & ~penable;
	wire wr_access = psel & penable & pwrite & mapped;
	wire [31:0] count_word = {id_capture_error, 7'h00, id_round_counter, 5'h00,
		id_quadlet_length, 2'h0};
	wire [31:0] rd_word = sel_base ? {id_buffer_base, 11'h000} :
		sel_count ? count_word :
		sel_ctrl ? {31'h0, accept_id_packets} : 32'h0;

	// ==========================================================
	// Event decode
	wire rst_rise  = bus_reset & ~br_q;
	wire rst_fall  = ~bus_reset & br_q;
	wire ph_fall   = ~id_phase & ph_q;
	wire start     = rst_fall & accept_id_packets; // R17
	wire active    = state_reg != id_capture_pkg::S_IDLE;
	wire capt      = state_reg == id_capture_pkg::S_CAPT;
	wire busy      = mem_reg.valid;
	wire mem_done  = busy & mem_ready;
	wire head_go   = state_reg == id_capture_pkg::S_HEAD & ~busy & ~bus_reset;
	wire take      = capt & id_in.valid & id_phase & accept_id_packets; // R12 R17
	wire overrun   = take & ~cap_err_reg & busy;
	wire overflow  = take & ~cap_err_reg & ~busy & idx_reg == id_capture_pkg::LAST_SLOT;
	wire pkt_go    = take & ~cap_err_reg & ~busy & ~overflow; // R14 R13
	wire wr_fail   = active & mem_done & mem_err; // R5
	wire err_now   = active & ~bus_reset & (overrun | overflow | wr_fail | rx_error); // R5
	wire finish    = capt & (pend_reg | ph_fall) & ~busy & ~bus_reset;
	wire [15:0] stamp = {bus_cycle_timer[id_capture_pkg::SEC_LSB +: 3],
		bus_cycle_timer[id_capture_pkg::TICK_LSB +: 13]}; // R11
	wire [31:0] head_word = {8'h00, id_round_counter, stamp}; // R10
	wire [31:0] slot_addr = {id_buffer_base, idx_reg, 2'b00}; // R1 R21

	// ==========================================================
	// APB answers with no wait state; read data captured in setup
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_reg;
	assign mem_wr  = mem_reg;
	assign fwd     = fwd_reg;
	assign bus_reset_event     = rst_evt_reg;
	assign id_phase_done_event = done_evt_reg;

	// Read data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
		end else if (setup) begin
			prdata_reg <= rd_word;
		end
	end

	// Buffer base, left without reset
	always_ff @(posedge pclk) begin
		if (wr_access && sel_base) begin
			id_buffer_base <= pwdata[31:BASE_OFF]; // R1 R2
		end
	end

	// Accept control bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_id_packets <= 1'b0;
		end else if (wr_access && sel_ctrl) begin
			accept_id_packets <= pwdata[id_capture_pkg::ACCEPT_BIT];
		end
	end

	// Edge history of reset and phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			br_q <= 1'b0;
			ph_q <= 1'b0;
		end else begin
			br_q <= bus_reset;
			ph_q <= id_phase;
		end
	end

	// Generation counter, wraps naturally at 8 bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_round_counter <= id_capture_pkg::GEN_RESET;
		end else if (start) begin
			id_round_counter <= id_round_counter + 8'h01; // R6
		end
	end

	// Capture sequencer; a new bus reset aborts and restarts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= id_capture_pkg::S_IDLE;
		end else if (rst_rise) begin
			state_reg <= id_capture_pkg::S_IDLE; // R9
		end else if (start) begin
			state_reg <= id_capture_pkg::S_HEAD; // R9
		end else begin
			unique case (state_reg)
				id_capture_pkg::S_IDLE: state_reg <= id_capture_pkg::S_IDLE;
				id_capture_pkg::S_HEAD: begin
					if (head_go) begin
						state_reg <= id_capture_pkg::S_CAPT;
					end
				end
				id_capture_pkg::S_CAPT: begin
					if (finish) begin
						state_reg <= id_capture_pkg::S_IDLE;
					end
				end
				default: state_reg <= id_capture_pkg::S_IDLE;
			endcase
		end
	end

	// Phase end seen while a write is still outstanding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_reg <= 1'b0;
		end else if (start || finish || rst_rise) begin
			pend_reg <= 1'b0;
		end else if (active && ph_fall) begin
			pend_reg <= 1'b1;
		end
	end

	// Write pointer index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_reg <= 9'h000;
		end else if (start) begin
			idx_reg <= 9'h000; // R21
		end else if (head_go || pkt_go) begin
			idx_reg <= idx_reg + 9'h001; // R21
		end
	end

	// Host write request, held until accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_reg <= '0;
		end else if (head_go) begin
			mem_reg <= {1'b1, slot_addr, head_word}; // R10 R11
		end else if (pkt_go) begin
			mem_reg <= {1'b1, slot_addr, id_in.data}; // R12 R13
		end else if (mem_done) begin
			mem_reg.valid <= 1'b0;
		end
	end

	// Length field, cleared with the bus-reset event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_quadlet_length <= 9'h000;
		end else if (rst_rise) begin
			id_quadlet_length <= 9'h000; // R7 R8
		end else if (active && overflow) begin
			id_quadlet_length <= id_capture_pkg::SIZE_FULL; // R15
		end else if (active && mem_done && !mem_err && !cap_err_reg) begin
			id_quadlet_length <= id_quadlet_length + 9'h001; // R21
		end
	end

	// Error flags: per capture and visible
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_err_reg      <= 1'b0;
			id_capture_error <= 1'b0;
		end else if (start) begin
			cap_err_reg <= 1'b0;
		end else if (err_now) begin
			cap_err_reg      <= 1'b1; // R14
			id_capture_error <= 1'b1; // R3 R15
		end else if (finish) begin
			id_capture_error <= cap_err_reg; // R4
		end
	end

	// Outside the phase packets go to the request path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_reg <= '0;
		end else begin
			fwd_reg.valid <= id_in.valid & ~id_phase; // R20
			fwd_reg.data  <= id_in.data;
		end
	end

	// Event pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_evt_reg  <= 1'b0;
			done_evt_reg <= 1'b0;
		end else begin
			rst_evt_reg  <= rst_rise; // R8
			done_evt_reg <= finish | (~active & ph_fall); // R19
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_len_clear;
		rst_rise |=> (id_quadlet_length == 9'h000 && bus_reset_event);
	endproperty
	a_len_clear: assert property (p_len_clear) else $error("length not cleared"); // R7 R8

	property p_gen_inc;
		start |=> id_round_counter == $past(id_round_counter) + 8'h01;
	endproperty
	a_gen_inc: assert property (p_gen_inc) else $error("generation not stepped"); // R6

	property p_head;
		head_go |=> (mem_wr.valid && mem_wr.data[23:16] == id_round_counter
			&& mem_wr.addr[10:0] == 11'h000);
	endproperty
	a_head: assert property (p_head) else $error("bad header write"); // R10 R1

	property p_stamp;
		head_go |=> mem_wr.data[15:0] == {$past(bus_cycle_timer[27:25]),
			$past(bus_cycle_timer[24:12])};
	endproperty
	a_stamp: assert property (p_stamp) else $error("bad time stamp"); // R11

	property p_accept;
		!accept_id_packets |-> !start && !pkt_go;
	endproperty
	a_accept: assert property (p_accept) else $error("captured while disabled"); // R17

	property p_discard;
		cap_err_reg && !start |-> !pkt_go;
	endproperty
	a_discard: assert property (p_discard) else $error("data after error"); // R14

	property p_wr_err;
		wr_fail && !bus_reset |=> id_capture_error ##1 1'b1;
	endproperty
	a_wr_err: assert property (p_wr_err) else $error("write error lost"); // R5 R3

	property p_clean_end;
		finish && !cap_err_reg && !err_now |=> !id_capture_error && id_phase_done_event;
	endproperty
	a_clean_end: assert property (p_clean_end) else $error("flag not cleared"); // R4 R19

	property p_ovf;
		overflow && !rst_rise |=> id_capture_error
			&& id_quadlet_length == id_capture_pkg::SIZE_FULL;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // R15

	property p_route;
		id_in.valid && !id_phase |=> fwd.valid && !$past(pkt_go);
	endproperty
	a_route: assert property (p_route) else $error("packet not forwarded"); // R20

	property p_restart;
		start |=> state_reg == id_capture_pkg::S_HEAD && idx_reg == 9'h000;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart"); // R9 R21

	property p_fwd_block;
		id_in.valid && id_phase |=> !fwd.valid;
	endproperty
	a_fwd_block: assert property (p_fwd_block) else $error("phase packet forwarded"); // R20

	property p_fwd_data;
		id_in.valid && !id_phase |=> fwd.data == $past(id_in.data);
	endproperty
	a_fwd_data: assert property (p_fwd_data) else $error("forwarded data wrong"); // R20

	property p_base_slot;
		$rose(mem_wr.valid) |-> mem_wr.addr[31:BASE_OFF] == $past(id_buffer_base);
	endproperty
	a_base_slot: assert property (p_base_slot) else $error("write outside buffer"); // R1

	property p_hold;
		mem_wr.valid && !mem_ready |=> mem_wr.valid && $stable(mem_wr.addr)
			&& $stable(mem_wr.data);
	endproperty
	a_hold: assert property (p_hold) else $error("write request dropped"); // R21

	property p_len_step;
		active && mem_done && !mem_err && !cap_err_reg && !rst_rise
			|=> id_quadlet_length == $past(id_quadlet_length) + 9'h001;
	endproperty
	a_len_step: assert property (p_len_step) else $error("length not stepped"); // R21 R7

	property p_err_set;
		err_now |=> id_capture_error && cap_err_reg;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error not latched"); // R3 R5

	property p_gen_hold;
		!start |=> id_round_counter == $past(id_round_counter);
	endproperty
	a_gen_hold: assert property (p_gen_hold) else $error("generation moved"); // R6
endmodule
`default_nettype wire

// ==== rtl/id_capture_pkg.sv ====
// Register map, field layout, carriers and states of the self-ID capture DMA
`default_nettype none
package id_capture_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_BASE  = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_CTRL  = 8'h08;
	// ==========================================================
	// Field positions
	localparam int BASE_LSB   = 11; // 2K-byte aligned base
	localparam int ERR_BIT    = 31;
	localparam int GEN_LSB    = 16;
	localparam int SIZE_LSB   = 2;
	localparam int ACCEPT_BIT = 0;
	localparam int SEC_LSB    = 25; // Seconds field of the cycle timer
	localparam int TICK_LSB   = 12; // Tick field of the cycle timer
	// ==========================================================
	// Reset values and limits
	localparam logic [7:0] GEN_RESET  = 8'h00;
	localparam logic [8:0] LAST_SLOT  = 9'h1ff; // 512th quadlet reaches 2048 bytes
	localparam logic [8:0] SIZE_FULL  = 9'h1ff; // Length field all ones
	// ==========================================================
	// Carriers and states
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} quad_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
	} mem_wr_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_HEAD = 3'b010,
		S_CAPT = 3'b100
	} state_t;
endpackage
`default_nettype wire

// ==== sim/phy_model.sv ====
// Physical-layer model that delivers self-ID traffic to the capture block
`default_nettype none
module phy_model (
	// Clock
	input  wire logic             pclk,
	// Receive path toward the block
	output logic                  bus_reset,
	output logic                  id_phase,
	output logic                  rx_error,
	output id_capture_pkg::quad_t id_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Quadlet pattern: data word, then its inverse
	function automatic logic [31:0] qw(input int i);
		logic [31:0] d;
		d = 32'h5e1f_0000 + 32'(i / 2);
		return i[0] ? ~d : d;
	endfunction
	// Idle levels
	initial begin
		bus_reset = 1'b0;
		id_phase = 1'b0;
		rx_error = 1'b0;
		id_in = '0;
	end
	// Bus reset begins; the self-ID phase closes with it
	task automatic br_on();
		@(posedge pclk);
		bus_reset <= 1'b1;
		id_phase <= 1'b0;
		@(posedge pclk);
	endtask
	// Bus reset ends; self-ID phase opens
	task automatic br_off();
		repeat (3) @(posedge pclk);
		bus_reset <= 1'b0;
		id_phase <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
	// Send n quadlets, a receive error in place of slot bad
	task automatic quad(input int n, input int bad);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rx_error <= (i == bad);
			id_in.valid <= (i != bad);
			id_in.data <= qw(i);
			@(posedge pclk);
			rx_error <= 1'b0;
			id_in.valid <= 1'b0;
			id_in.data <= ~qw(i); // Released data never keeps its value
			@(posedge pclk);
		end
	endtask
	// First subaction gap ends the phase
	task automatic gap();
		repeat (2) @(posedge pclk);
		id_phase <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== sim/id_capture_dma_tb.sv ====
// Self-checking bench for the self-ID capture DMA
`default_nettype none
module id_capture_dma_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Stimulus, responses and bookkeeping
	logic                    pclk = 1'b0;
	logic                    presetn = 1'b0;
	logic [7:0]              paddr = 8'h00;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata, rd, base;
	logic                    pready, pslverr, slv, brev, done_ev, mem_err;
	logic                    bus_reset, id_phase, rx_error;
	id_capture_pkg::quad_t   id_in, fwd;
	id_capture_pkg::mem_wr_t mem_wr;
	logic [31:0]             tmr = 32'h1234_5678;
	logic                    mem_ready = 1'b1;
	logic                    stall = 1'b0;
	logic [31:0]             fwd_data = 32'h0;
	logic [31:0]             mem [512];
	logic [7:0]              gen = 8'h00;
	logic                    fwd_seen = 1'b0, done_seen = 1'b0, bad_addr = 1'b0;
	int                      wr_cnt = 0, err_at = -1, num_errors = 0, checks_done = 0, cyc = 0;
	always #4 pclk = ~pclk;
	assign mem_err = (wr_cnt == err_at);
	id_capture_dma DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_reset(bus_reset), .id_phase(id_phase), .rx_error(rx_error),
		.id_in(id_in), .bus_cycle_timer(tmr), .mem_wr(mem_wr), .mem_ready(mem_ready),
		.mem_err(mem_err), .fwd(fwd), .bus_reset_event(brev), .id_phase_done_event(done_ev));
	phy_model phy (.pclk(pclk), .bus_reset(bus_reset), .id_phase(id_phase),
		.rx_error(rx_error), .id_in(id_in));
	// Host memory, event watch and hang limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		mem_ready <= stall ? ~mem_ready : 1'b1;
		if (fwd.valid) begin
			fwd_seen <= 1'b1;
			fwd_data <= fwd.data;
		end
		if (done_ev) done_seen <= 1'b1;
		if (mem_wr.valid && mem_ready) begin
			mem[mem_wr.addr[10:2]] <= mem_wr.data;
			wr_cnt <= wr_cnt + 1;
			if (mem_wr.addr[31:11] !== base[31:11]) bad_addr <= 1'b1;
		end
		if (cyc == 30000) begin
			num_errors++;
			end_sim();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cnt(input logic e, input logic [8:0] len);
		apb(1'b0, id_capture_pkg::OFF_COUNT, 32'h0);
		chk(rd, {e, 7'h00, gen, 5'h00, len, 2'b00});
	endtask
	task automatic cap(input int n, input int bad);
		wr_cnt = 0;
		done_seen = 1'b0;
		phy.br_on();
		phy.br_off();
		gen++;
		phy.quad(n, bad);
		phy.gap();
		repeat (4) @(posedge pclk);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		apb(1'b1, id_capture_pkg::OFF_BASE, 32'hdead_beef);
		apb(1'b0, id_capture_pkg::OFF_BASE, 32'h0);
		chk(rd, 32'hdead_b800);
		base = 32'hdead_b800;
		cnt(1'b0, 9'h000);
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, slv}, 32'h1);
		apb(1'b1, id_capture_pkg::OFF_CTRL, 32'h1);
		$display("test regs done");
	endtask
	task automatic t_capture();
		cap(4, -1);
		chk(mem[0], {8'h00, gen, tmr[27:25], tmr[24:12]});
		for (int i = 0; i < 4; i++) chk(mem[i + 1], phy.qw(i));
		cnt(1'b0, 9'h005);
		chk({24'h0, mem[0][23:16]}, {24'h0, rd[23:16]});
		chk({31'h0, done_seen}, 32'h1);
		chk({31'h0, bad_addr}, 32'h0);
		$display("test capture done");
	endtask
	task automatic t_restart();
		phy.br_on();
		phy.br_off();
		gen++;
		phy.quad(2, -1);
		phy.br_on();
		#1;
		chk({31'h0, brev}, 32'h1);
		cnt(1'b0, 9'h000);
		phy.br_off();
		gen++;
		phy.quad(1, -1);
		phy.gap();
		repeat (4) @(posedge pclk);
		chk({24'h0, mem[0][23:16]}, {24'h0, gen});
		cnt(1'b0, 9'h002);
		$display("test restart done");
	endtask
	task automatic t_errors();
		err_at = 2;
		cap(4, -1);
		err_at = -1;
		chk(32'(wr_cnt), 32'd3);
		cnt(1'b1, 9'h002);
		cap(4, 1);
		chk(32'(wr_cnt), 32'd2);
		cnt(1'b1, 9'h002);
		stall = 1'b1;
		cap(2, -1);
		stall = 1'b0;
		chk(32'(wr_cnt), 32'd3);
		cnt(1'b0, 9'h003);
		cap(520, -1);
		chk(32'(wr_cnt), 32'd511);
		cnt(1'b1, 9'h1ff);
		$display("test errors done");
	endtask
	task automatic t_wrap_off();
		repeat (250) cap(0, -1);
		cnt(1'b0, 9'h001);
		apb(1'b1, id_capture_pkg::OFF_CTRL, 32'h0);
		cap(2, -1);
		chk(32'(wr_cnt), 32'd0);
		gen--;
		cnt(1'b0, 9'h000);
		fwd_seen = 1'b0;
		phy.quad(1, -1);
		repeat (2) @(posedge pclk);
		chk({31'h0, fwd_seen}, 32'h1);
		chk(fwd_data, phy.qw(0));
		$display("test wrap and disable done");
	endtask
	task automatic end_sim();
		$display("checks=%0d errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_capture();
		t_restart();
		t_errors();
		t_wrap_off();
		end_sim();
	end
endmodule
`default_nettype wire
